// >>> rtl/mbie_top.sv
`timescale 1ns/1ps
`default_nettype none
module mbie_top (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  logic [31:0] prdata_ff, nxt_prdata;
  logic ready_ff, err_ff, nxt_err;
  logic [5:0] op_ff;
  logic [15:0] instr_ff, ext_ff, oplo_ff, ophi_ff, pc_ff, result_ff;
  logic [6:0] ind_ff;
  logic trap_ff, taken_ff, sfrom_r1_ff;
  logic [3:0] vec_ff, stype_ff;
  logic [4:0] sdist_ff;
  logic [15:0] gpr_ff [8];
  mbie_pkg::mbie_state_t state_ff;
  logic wr_go, rd_en, busy;
  logic [2:0] gidx, rsel;
  logic [15:0] rval, r1val, tval, dec_val, inc_val, target, seq_pc;
  logic [15:0] cmp_a, cmp_b, half_sx, imm_sx, mask;
  logic [32:0] dsum;
  logic is_br, take, exec;
  logic [7:0] gpr_we;
  logic [15:0] gpr_wd [8];

  assign exec = (state_ff == mbie_pkg::MBIE_EXEC);
  assign busy = exec;
  assign pready = ready_ff;
  assign prdata = prdata_ff;
  assign pslverr = ready_ff & err_ff;
  assign wr_go = psel & penable & ready_ff & pwrite;
  assign rd_en = psel & penable & !ready_ff;
  localparam int GIDX_MSB = 4;
  assign gidx = paddr[GIDX_MSB:mbie_pkg::GPR_IDX_LSB];
  assign rsel = instr_ff[14:12];
  assign rval = gpr_ff[rsel];
  assign r1val = gpr_ff[mbie_pkg::REG_MASK_SRC];

  // One wait state per access so read data settles after any execution
  always_ff @(posedge clk) begin
    if (srst) begin
      ready_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      err_ff <= 1'b0;
    end else begin
      ready_ff <= rd_en;
      if (rd_en) begin
        prdata_ff <= nxt_prdata;
        err_ff <= nxt_err;
      end
    end
  end

  // Read decode; unmapped offsets read zero and raise pslverr
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    nxt_err = 1'b0;
    if (paddr[1:0] != 2'h0) begin
      nxt_err = 1'b1;
    end else if (paddr >= mbie_pkg::OFF_GPR && paddr < mbie_pkg::OFF_GPR + mbie_pkg::GPR_SPAN) begin
      nxt_prdata = {16'h0000, gpr_ff[gidx]};
    end else begin
      case (paddr)
        mbie_pkg::OFF_CTRL: nxt_prdata = {26'h000_0000, op_ff};
        mbie_pkg::OFF_INSTR: nxt_prdata = {16'h0000, instr_ff};
        mbie_pkg::OFF_EXT: nxt_prdata = {16'h0000, ext_ff};
        mbie_pkg::OFF_OPLO: nxt_prdata = {16'h0000, oplo_ff};
        mbie_pkg::OFF_OPHI: nxt_prdata = {16'h0000, ophi_ff};
        mbie_pkg::OFF_PC: nxt_prdata = {16'h0000, pc_ff};
        mbie_pkg::OFF_IND: nxt_prdata = {25'h000_0000, ind_ff};
        mbie_pkg::OFF_RESULT: nxt_prdata = {16'h0000, result_ff};
        mbie_pkg::OFF_STAT: begin
          nxt_prdata[mbie_pkg::ST_TRAP] = trap_ff;
          nxt_prdata[mbie_pkg::ST_VEC_LSB +: 4] = vec_ff;
          nxt_prdata[mbie_pkg::ST_TAKEN] = taken_ff;
          nxt_prdata[mbie_pkg::ST_SDIST_LSB +: 5] = sdist_ff;
          nxt_prdata[mbie_pkg::ST_STYPE_LSB +: 4] = stype_ff;
          nxt_prdata[mbie_pkg::ST_SFROM_R1] = sfrom_r1_ff;
          nxt_prdata[mbie_pkg::ST_BUSY] = busy;
        end
        default: nxt_err = 1'b1;
      endcase
    end
  end

  // Software-loaded instruction context
  always_ff @(posedge clk) begin
    if (srst) begin
      op_ff <= 6'h00;
      instr_ff <= 16'h0000;
      ext_ff <= 16'h0000;
      oplo_ff <= 16'h0000;
      ophi_ff <= 16'h0000;
    end else if (wr_go) begin
      case (paddr)
        mbie_pkg::OFF_CTRL: op_ff <= pwdata[5:0];
        mbie_pkg::OFF_INSTR: instr_ff <= pwdata[15:0];
        mbie_pkg::OFF_EXT: ext_ff <= pwdata[15:0];
        mbie_pkg::OFF_OPLO: oplo_ff <= pwdata[15:0];
        mbie_pkg::OFF_OPHI: ophi_ff <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // A CTRL write launches exactly one execution cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= mbie_pkg::MBIE_IDLE;
    end else begin
      case (state_ff)
        mbie_pkg::MBIE_IDLE: if (wr_go && paddr == mbie_pkg::OFF_CTRL) state_ff <= mbie_pkg::MBIE_EXEC;
        mbie_pkg::MBIE_EXEC: state_ff <= mbie_pkg::MBIE_IDLE;
        default: state_ff <= mbie_pkg::MBIE_IDLE;
      endcase
    end
  end

  // Operand shaping and branch addressing
  always_comb begin
    dec_val = rval + mbie_pkg::ALL_ONES;
    inc_val = rval + mbie_pkg::ONE;
    half_sx = {{8{oplo_ff[7]}}, oplo_ff[7:0]};
    imm_sx = {{8{instr_ff[7]}}, instr_ff[7:0]};
    mask = (ext_ff == mbie_pkg::ZERO) ? r1val : ext_ff;
    if (op_ff == mbie_pkg::OP_DEC_BRANCH) tval = dec_val;
    else if (op_ff == mbie_pkg::OP_INC_BRANCH) tval = inc_val;
    else tval = rval;
    // Pointer and long forms own one extra word; short form is in-line
    if (instr_ff[6:0] == mbie_pkg::DISP_PTR) begin
      target = ext_ff;
      seq_pc = pc_ff + mbie_pkg::SEQ_LONG;
    end else if (instr_ff[6:0] == mbie_pkg::DISP_LONG) begin
      target = pc_ff + ext_ff;
      seq_pc = pc_ff + mbie_pkg::SEQ_LONG;
    end else begin
      target = pc_ff + {{9{instr_ff[6]}}, instr_ff[6:0]};
      seq_pc = pc_ff + mbie_pkg::SEQ_SHORT;
    end
    case (op_ff)
      mbie_pkg::OP_COMPARE_HALF: begin cmp_a = rval; cmp_b = half_sx; end
      mbie_pkg::OP_COMPARE_IMM: begin cmp_a = rval; cmp_b = imm_sx; end
      mbie_pkg::OP_COMPARE_ZERO: begin cmp_a = oplo_ff; cmp_b = mbie_pkg::ZERO; end
      default: begin cmp_a = rval; cmp_b = oplo_ff; end
    endcase
    dsum = {1'b0, gpr_ff[mbie_pkg::REG_PAIR_HI], gpr_ff[mbie_pkg::REG_PAIR_LO]} + {1'b0, ophi_ff, oplo_ff};
  end

  mbie_branch_cond u_cond (
    .op(op_ff),
    .ind(ind_ff),
    .tval(tval),
    .is_branch(is_br),
    .take(take)
  );

  // Program counter: branch target, sequential step, or software load
  always_ff @(posedge clk) begin
    if (srst) begin
      pc_ff <= 16'h0000;
    end else if (exec && is_br) begin
      pc_ff <= take ? target : seq_pc;
    end else if (exec) begin
      pc_ff <= seq_pc;
    end else if (wr_go && paddr == mbie_pkg::OFF_PC) begin
      pc_ff <= pwdata[15:0];
    end
  end

  // Indicator register updated by compares and doubleword add
  always_ff @(posedge clk) begin
    if (srst) begin
      ind_ff <= 7'h00;
    end else if (exec && (op_ff == mbie_pkg::OP_COMPARE_WORD || op_ff == mbie_pkg::OP_COMPARE_HALF ||
                          op_ff == mbie_pkg::OP_COMPARE_IMM || op_ff == mbie_pkg::OP_COMPARE_ZERO)) begin
      ind_ff[mbie_pkg::IND_G] <= $signed(cmp_a) > $signed(cmp_b);
      ind_ff[mbie_pkg::IND_L] <= $signed(cmp_a) < $signed(cmp_b);
      ind_ff[mbie_pkg::IND_U] <= cmp_a[15] ^ cmp_b[15];
    end else if (exec && op_ff == mbie_pkg::OP_DWORD_ADD) begin
      ind_ff[mbie_pkg::IND_C] <= dsum[32];
      ind_ff[mbie_pkg::IND_OV] <= (gpr_ff[mbie_pkg::REG_PAIR_HI][15] == ophi_ff[15]) &&
                                  (dsum[31] != ophi_ff[15]);
    end else if (wr_go && paddr == mbie_pkg::OFF_IND) begin
      ind_ff <= pwdata[6:0];
    end
  end

  // Write-back selection for the general registers
  always_comb begin
    gpr_we = 8'h00;
    for (int i = 0; i < 8; i++) gpr_wd[i] = pwdata[15:0];
    if (exec) begin
      case (op_ff)
        mbie_pkg::OP_DEC_BRANCH: begin gpr_we[rsel] = 1'b1; gpr_wd[rsel] = dec_val; end
        mbie_pkg::OP_INC_BRANCH: begin gpr_we[rsel] = 1'b1; gpr_wd[rsel] = inc_val; end
        mbie_pkg::OP_HALF_AND: begin gpr_we[rsel] = 1'b1; gpr_wd[rsel] = rval & half_sx; end
        mbie_pkg::OP_DWORD_ADD: begin
          gpr_we[mbie_pkg::REG_PAIR_HI] = 1'b1;
          gpr_wd[mbie_pkg::REG_PAIR_HI] = dsum[31:16];
          gpr_we[mbie_pkg::REG_PAIR_LO] = 1'b1;
          gpr_wd[mbie_pkg::REG_PAIR_LO] = dsum[15:0];
        end
        default: ;
      endcase
    end else if (wr_go && paddr >= mbie_pkg::OFF_GPR && paddr < mbie_pkg::OFF_GPR + mbie_pkg::GPR_SPAN) begin
      gpr_we[gidx] = 1'b1;
    end
  end

  // General register file, one flop word per entry
  for (genvar g = 0; g < 8; g++) begin : g_gpr
    always_ff @(posedge clk) begin
      if (srst) gpr_ff[g] <= 16'h0000;
      else if (gpr_we[g]) gpr_ff[g] <= gpr_wd[g];
    end
  end

  // Masked store result and shift field decode
  always_ff @(posedge clk) begin
    if (srst) begin
      result_ff <= 16'h0000;
      sdist_ff <= 5'h00;
      stype_ff <= 4'h0;
      sfrom_r1_ff <= 1'b0;
    end else if (exec) begin
      case (op_ff)
        mbie_pkg::OP_MASK_STORE: result_ff <= (rval & mask) | (oplo_ff & ~mask);
        mbie_pkg::OP_MASK_DECODE: result_ff <= mask;
        mbie_pkg::OP_SHIFT_SHORT: begin
          sfrom_r1_ff <= (instr_ff[3:0] == 4'h0);
          sdist_ff <= (instr_ff[3:0] == 4'h0) ? {1'b0, r1val[3:0]} : {1'b0, instr_ff[3:0]};
          stype_ff <= instr_ff[7:4];
        end
        mbie_pkg::OP_SHIFT_LONG: begin
          sfrom_r1_ff <= (instr_ff[4:0] == 5'h00);
          sdist_ff <= (instr_ff[4:0] == 5'h00) ? r1val[4:0] : instr_ff[4:0];
          stype_ff <= {1'b0, instr_ff[7:5]};
        end
        default: ;
      endcase
    end
  end

  // Trap flag: breakpoint sets, write-one clears, set wins
  always_ff @(posedge clk) begin
    if (srst) begin
      trap_ff <= 1'b0;
      vec_ff <= 4'h0;
      taken_ff <= 1'b0;
    end else begin
      if (exec && op_ff == mbie_pkg::OP_BKPT_TRAP) begin
        trap_ff <= 1'b1;
        vec_ff <= mbie_pkg::TRAP_VEC_BRK;
      end else if (wr_go && paddr == mbie_pkg::OFF_STAT && pwdata[mbie_pkg::ST_TRAP]) begin
        trap_ff <= 1'b0;
      end
      if (exec) taken_ff <= is_br & take;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_exec_op(logic [5:0] o);
    exec && op_ff == o;
  endsequence
  sequence s_wait_then_done;
    rd_en ##1 pready;
  endsequence

  chk_branch_taken: assert property (exec && is_br && take |=> pc_ff == $past(target))
    else $error("taken branch did not load target");
  chk_branch_seq: assert property (exec && is_br && !take |=> pc_ff == $past(seq_pc))
    else $error("untaken branch wrong next address");
  chk_dec_value: assert property (s_exec_op(mbie_pkg::OP_DEC_BRANCH) |=>
    gpr_ff[$past(rsel)] == $past(rval) - 16'h0001 && taken_ff == ($past(rval) != 16'h0000))
    else $error("decrement branch wrong");
  chk_inc_value: assert property (s_exec_op(mbie_pkg::OP_INC_BRANCH) |=>
    gpr_ff[$past(rsel)] == $past(rval) + 16'h0001 && taken_ff == ($past(rval) != 16'hFFFF))
    else $error("increment branch wrong");
  chk_trap_vector: assert property (s_exec_op(mbie_pkg::OP_BKPT_TRAP) |=> trap_ff && vec_ff == mbie_pkg::TRAP_VEC_BRK &&
    gpr_ff[7] == $past(gpr_ff[7]))
    else $error("breakpoint trap missing");
  chk_compare_keeps: assert property (s_exec_op(mbie_pkg::OP_COMPARE_WORD) |=>
    $stable(gpr_ff[rsel]) && ind_ff[mbie_pkg::IND_U] == ($past(rval[15]) ^ $past(oplo_ff[15])))
    else $error("compare altered operand or signs");
  chk_dword_sum: assert property (s_exec_op(mbie_pkg::OP_DWORD_ADD) |=>
    {gpr_ff[6], gpr_ff[7]} == $past({gpr_ff[6], gpr_ff[7]}) + $past({ophi_ff, oplo_ff}))
    else $error("doubleword add sum wrong");
  chk_half_and: assert property (s_exec_op(mbie_pkg::OP_HALF_AND) |=>
    gpr_ff[$past(rsel)] == ($past(rval) & {{8{$past(oplo_ff[7])}}, $past(oplo_ff[7:0])}))
    else $error("halfword and wrong");
  chk_shift_src: assert property (s_exec_op(mbie_pkg::OP_SHIFT_LONG) && instr_ff[4:0] == 5'h00 |=>
    sfrom_r1_ff && sdist_ff == $past(gpr_ff[1][4:0]))
    else $error("zero shift distance not from R1");
  chk_apb_wait: assert property (s_wait_then_done |-> ##1 !pready)
    else $error("apb wait state broken");
endmodule
`default_nettype wire

// >>> rtl/mbie_pkg.sv
package mbie_pkg;
  // APB byte offsets, one aligned word each except the eight-word GPR window at OFF_GPR
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_INSTR = 8'h04;
  localparam logic [7:0] OFF_EXT = 8'h08;
  localparam logic [7:0] OFF_OPLO = 8'h0C;
  localparam logic [7:0] OFF_OPHI = 8'h10;
  localparam logic [7:0] OFF_PC = 8'h14;
  localparam logic [7:0] OFF_IND = 8'h18;
  localparam logic [7:0] OFF_STAT = 8'h1C;
  localparam logic [7:0] OFF_RESULT = 8'h20;
  localparam logic [7:0] OFF_GPR = 8'h40;
  localparam logic [2:0] GPR_IDX_LSB = 3'h2;
  localparam logic [7:0] GPR_SPAN = 8'h20;
  // Indicator bit positions
  localparam int IND_W = 7;
  localparam int IND_OV = 0;
  localparam int IND_C = 1;
  localparam int IND_G = 2;
  localparam int IND_L = 3;
  localparam int IND_U = 4;
  localparam int IND_B = 5;
  localparam int IND_I = 6;
  // Status fields
  localparam int ST_TRAP = 0;
  localparam int ST_VEC_LSB = 4;
  localparam int ST_TAKEN = 8;
  localparam int ST_SDIST_LSB = 9;
  localparam int ST_STYPE_LSB = 14;
  localparam int ST_SFROM_R1 = 18;
  localparam int ST_BUSY = 19;
  localparam logic [3:0] TRAP_VEC_BRK = 4'h2;
  // Register numbers and constants
  localparam logic [2:0] REG_MASK_SRC = 3'h1;
  localparam logic [2:0] REG_PAIR_HI = 3'h6;
  localparam logic [2:0] REG_PAIR_LO = 3'h7;
  localparam logic [15:0] ALL_ONES = 16'hFFFF;
  localparam logic [15:0] ONE = 16'h0001;
  localparam logic [15:0] ZERO = 16'h0000;
  localparam logic [6:0] DISP_PTR = 7'h00;
  localparam logic [6:0] DISP_LONG = 7'h01;
  localparam logic [15:0] SEQ_LONG = 16'h0002;
  localparam logic [15:0] SEQ_SHORT = 16'h0001;
  // Operation codes written to CTRL
  localparam logic [5:0] OP_BR_ALWAYS = 6'h00;
  localparam logic [5:0] OP_ALG_GT = 6'h01;
  localparam logic [5:0] OP_ALG_GE = 6'h02;
  localparam logic [5:0] OP_ALG_LT = 6'h03;
  localparam logic [5:0] OP_ALG_LE = 6'h04;
  localparam logic [5:0] OP_BIT_F = 6'h05;
  localparam logic [5:0] OP_BIT_T = 6'h06;
  localparam logic [5:0] OP_CY_F = 6'h07;
  localparam logic [5:0] OP_CY_T = 6'h08;
  localparam logic [5:0] OP_IO_F = 6'h09;
  localparam logic [5:0] OP_IO_T = 6'h0A;
  localparam logic [5:0] OP_OV_T = 6'h0B;
  localparam logic [5:0] OP_OV_F = 6'h0C;
  localparam logic [5:0] OP_SGN_EQ = 6'h0D;
  localparam logic [5:0] OP_SGN_UN = 6'h0E;
  localparam logic [5:0] OP_CMP_GT = 6'h0F;
  localparam logic [5:0] OP_CMP_GE = 6'h10;
  localparam logic [5:0] OP_CMP_LT = 6'h11;
  localparam logic [5:0] OP_CMP_LE = 6'h12;
  localparam logic [5:0] OP_CMP_EQ = 6'h13;
  localparam logic [5:0] OP_CMP_NE = 6'h14;
  localparam logic [5:0] OP_R_EZ = 6'h15;
  localparam logic [5:0] OP_R_NEZ = 6'h16;
  localparam logic [5:0] OP_R_EVEN = 6'h17;
  localparam logic [5:0] OP_R_ODD = 6'h18;
  localparam logic [5:0] OP_R_GEZ = 6'h19;
  localparam logic [5:0] OP_R_LZ = 6'h1A;
  localparam logic [5:0] OP_R_GZ = 6'h1B;
  localparam logic [5:0] OP_R_LEZ = 6'h1C;
  localparam logic [5:0] OP_DEC_BRANCH = 6'h1D;
  localparam logic [5:0] OP_INC_BRANCH = 6'h1E;
  localparam logic [5:0] OP_COMPARE_WORD = 6'h20;
  localparam logic [5:0] OP_COMPARE_HALF = 6'h21;
  localparam logic [5:0] OP_COMPARE_IMM = 6'h22;
  localparam logic [5:0] OP_COMPARE_ZERO = 6'h23;
  localparam logic [5:0] OP_DWORD_ADD = 6'h24;
  localparam logic [5:0] OP_HALF_AND = 6'h25;
  localparam logic [5:0] OP_BKPT_TRAP = 6'h26;
  localparam logic [5:0] OP_SHIFT_SHORT = 6'h27;
  localparam logic [5:0] OP_SHIFT_LONG = 6'h28;
  localparam logic [5:0] OP_MASK_STORE = 6'h29;
  localparam logic [5:0] OP_MASK_DECODE = 6'h2A;
  typedef enum logic [1:0] {
    MBIE_IDLE = 2'b01,
    MBIE_EXEC = 2'b10
  } mbie_state_t;
endpackage

// >>> rtl/mbie_branch_cond.sv
`timescale 1ns/1ps
`default_nettype none
module mbie_branch_cond (
  // Selection and operands
  input wire logic [5:0] op,
  input wire logic [6:0] ind,
  input wire logic [15:0] tval,
  // Decision
  output logic is_branch,
  output logic take
);
  logic ov, cy, g, l, u, b, io, zr;

  // Indicator and register tests for every branch form
  always_comb begin
    ov = ind[mbie_pkg::IND_OV];
    cy = ind[mbie_pkg::IND_C];
    g = ind[mbie_pkg::IND_G];
    l = ind[mbie_pkg::IND_L];
    u = ind[mbie_pkg::IND_U];
    b = ind[mbie_pkg::IND_B];
    io = ind[mbie_pkg::IND_I];
    zr = (tval == mbie_pkg::ZERO);
    is_branch = 1'b1;
    case (op)
      mbie_pkg::OP_BR_ALWAYS: take = 1'b1;
      mbie_pkg::OP_ALG_GT: take = (g ^ u);
      mbie_pkg::OP_ALG_GE: take = !(l ^ u);
      mbie_pkg::OP_ALG_LT: take = (l ^ u);
      mbie_pkg::OP_ALG_LE: take = !(g ^ u);
      mbie_pkg::OP_BIT_F: take = !b;
      mbie_pkg::OP_BIT_T: take = b;
      mbie_pkg::OP_CY_F: take = !cy;
      mbie_pkg::OP_CY_T: take = cy;
      mbie_pkg::OP_IO_F: take = !io;
      mbie_pkg::OP_IO_T: take = io;
      mbie_pkg::OP_OV_T: take = ov;
      mbie_pkg::OP_OV_F: take = !ov;
      mbie_pkg::OP_SGN_EQ: take = !u;
      mbie_pkg::OP_SGN_UN: take = u;
      mbie_pkg::OP_CMP_GT: take = g;
      mbie_pkg::OP_CMP_GE: take = !l;
      mbie_pkg::OP_CMP_LT: take = l;
      mbie_pkg::OP_CMP_LE: take = !g;
      mbie_pkg::OP_CMP_EQ: take = !(l | g);
      mbie_pkg::OP_CMP_NE: take = (l | g);
      mbie_pkg::OP_R_EZ: take = zr;
      mbie_pkg::OP_R_NEZ: take = !zr;
      mbie_pkg::OP_R_EVEN: take = !tval[0];
      mbie_pkg::OP_R_ODD: take = tval[0];
      mbie_pkg::OP_R_GEZ: take = !tval[15];
      mbie_pkg::OP_R_LZ: take = tval[15];
      mbie_pkg::OP_R_GZ: take = !tval[15] && (tval[14:0] != 15'h0000);
      mbie_pkg::OP_R_LEZ: take = tval[15] || zr;
      mbie_pkg::OP_DEC_BRANCH: take = (tval != mbie_pkg::ALL_ONES);
      mbie_pkg::OP_INC_BRANCH: take = !zr;
      default: begin
        is_branch = 1'b0;
        take = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

// >>> tb/mbie_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mbie_top_tb;
  logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr;
  int failures = 0, n_checks = 0;
  mbie_top dut_u (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // 125 MHz clock
  always #4 clk = ~clk;
  // One APB transfer; an idle cycle after it keeps drivers from double assignment
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) failures++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, {16'h0, d}, q, e);
  endtask
  // Read, mask, compare
  task automatic rc(input string s, input logic [7:0] a, input logic [31:0] m, x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(s, x, q & m);
  endtask
  function automatic logic [7:0] ga(input int n);
    return mbie_pkg::OFF_GPR + 8'(4 * n);
  endfunction
  // Operands first, opcode last since the opcode write launches execution
  task automatic ex(input logic [5:0] op, input logic [15:0] ins, ext, ind);
    wr(mbie_pkg::OFF_INSTR, ins);
    wr(mbie_pkg::OFF_EXT, ext);
    wr(mbie_pkg::OFF_PC, 16'h0100);
    wr(mbie_pkg::OFF_IND, ind);
    wr(mbie_pkg::OFF_CTRL, {10'h0, op});
  endtask
  task automatic t_ind;
    logic [6:0] iv [20] = '{7'h14, 7'h18, 7'h08, 7'h04, 7'h20, 7'h20, 7'h00, 7'h02, 7'h40, 7'h00,
      7'h01, 7'h01, 7'h10, 7'h10, 7'h04, 7'h08, 7'h04, 7'h08, 7'h00, 7'h0C};
    bit tk [20] = '{0, 1, 1, 0, 0, 1, 1, 1, 0, 0, 1, 0, 0, 1, 1, 0, 0, 1, 1, 1};
    for (int i = 0; i < 20; i++) begin
      ex(6'(i + 1), 16'h0000, 16'h0200, {9'h0, iv[i]});
      rc("ind pc", mbie_pkg::OFF_PC, 32'hFFFF, tk[i] ? 32'h0200 : 32'h0102);
      rc("taken", mbie_pkg::OFF_STAT, 32'h100, {23'h0, tk[i], 8'h0});
    end
  endtask
  task automatic t_reg;
    logic [15:0] v [12] = '{16'h0, 16'h0, 16'h1, 16'h1, 16'h8000, 16'h8000, 16'h0, 16'h0, 16'h1, 16'h8001,
      16'h1, 16'hFFFE};
    int k [12] = '{0, 1, 2, 3, 4, 5, 6, 7, 6, 6, 7, 2};
    bit tk [12] = '{1, 0, 0, 1, 0, 1, 0, 1, 1, 0, 0, 1};
    for (int i = 0; i < 12; i++) begin
      wr(ga(3), v[i]);
      ex(mbie_pkg::OP_R_EZ + 6'(k[i]), 16'h3000, 16'h0200, 16'h0);
      rc("reg pc", mbie_pkg::OFF_PC, 32'hFFFF, tk[i] ? 32'h0200 : 32'h0102);
    end
  endtask
  // Counts across the all-ones and zero boundaries
  task automatic t_cnt;
    logic [15:0] v [4] = '{16'h0, 16'h1, 16'hFFFF, 16'h0};
    logic [15:0] r [4] = '{16'hFFFF, 16'h0, 16'h0, 16'h1};
    bit tk [4] = '{0, 1, 0, 1};
    for (int i = 0; i < 4; i++) begin
      wr(ga(5), v[i]);
      ex(i < 2 ? mbie_pkg::OP_DEC_BRANCH : mbie_pkg::OP_INC_BRANCH, 16'h5000, 16'h0200, 16'h0);
      rc("cnt reg", ga(5), 32'hFFFF, {16'h0, r[i]});
      rc("cnt pc", mbie_pkg::OFF_PC, 32'hFFFF, tk[i] ? 32'h0200 : 32'h0102);
    end
  endtask
  task automatic t_disp;
    ex(mbie_pkg::OP_BR_ALWAYS, 16'h0001, 16'h0010, 16'h0);
    rc("long", mbie_pkg::OFF_PC, 32'hFFFF, 32'h0110);
    ex(mbie_pkg::OP_BR_ALWAYS, 16'h0040, 16'h0010, 16'h0);
    rc("short", mbie_pkg::OFF_PC, 32'hFFFF, 32'h00C0);
    ex(mbie_pkg::OP_BIT_T, 16'h0001, 16'h0010, 16'h0);
    rc("long seq", mbie_pkg::OFF_PC, 32'hFFFF, 32'h0102);
    ex(mbie_pkg::OP_BIT_T, 16'h0005, 16'h0010, 16'h0);
    rc("short seq", mbie_pkg::OFF_PC, 32'hFFFF, 32'h0101);
  endtask
  task automatic t_brk;
    wr(ga(0), 16'h1234);
    ex(mbie_pkg::OP_BKPT_TRAP, 16'h0, 16'h0, 16'h15);
    rc("trap", mbie_pkg::OFF_STAT, 32'hF1, 32'h21);
    rc("brk ind", mbie_pkg::OFF_IND, 32'h7F, 32'h15);
    rc("brk reg", ga(0), 32'hFFFF, 32'h1234);
    wr(mbie_pkg::OFF_STAT, 16'h1);
    rc("trap clr", mbie_pkg::OFF_STAT, 32'h1, 32'h0);
  endtask
  // The last pair has unlike signs, so the signed order and the unlike-signs indicator both matter
  task automatic t_cmp;
    logic [5:0] op [6] = '{mbie_pkg::OP_COMPARE_WORD, mbie_pkg::OP_COMPARE_HALF, mbie_pkg::OP_COMPARE_IMM,
      mbie_pkg::OP_COMPARE_IMM, mbie_pkg::OP_COMPARE_ZERO, mbie_pkg::OP_COMPARE_WORD};
    logic [15:0] r [6] = '{16'h5, 16'hFFFF, 16'h1, 16'hFF80, 16'h0, 16'hFFFF};
    logic [15:0] o [6] = '{16'h7, 16'hFF, 16'h0, 16'h0, 16'h3, 16'h1};
    logic [15:0] v [6] = '{16'h0, 16'h0, 16'h7F, 16'h80, 16'h0, 16'h0};
    logic [31:0] x [6] = '{32'h08, 32'h00, 32'h08, 32'h00, 32'h04, 32'h18};
    for (int i = 0; i < 6; i++) begin
      wr(ga(4), r[i]);
      wr(mbie_pkg::OFF_OPLO, o[i]);
      ex(op[i], 16'h4000 | v[i], 16'h0, 16'h1C);
      rc("cmp ind", mbie_pkg::OFF_IND, 32'h1C, x[i]);
      rc("cmp reg", ga(4), 32'hFFFF, {16'h0, r[i]});
    end
  endtask
  task automatic t_dadd;
    logic [31:0] a [3] = '{32'h0001FFFF, 32'h7FFFFFFF, 32'hFFFFFFFF};
    logic [31:0] s [3] = '{32'h00020000, 32'h80000000, 32'h0};
    logic [31:0] f [3] = '{32'h0, 32'h1, 32'h2};
    for (int i = 0; i < 3; i++) begin
      wr(ga(6), a[i][31:16]);
      wr(ga(7), a[i][15:0]);
      wr(mbie_pkg::OFF_OPHI, 16'h0);
      wr(mbie_pkg::OFF_OPLO, 16'h1);
      ex(mbie_pkg::OP_DWORD_ADD, 16'h0, 16'h0, 16'h0);
      rc("r6", ga(6), 32'hFFFF, {16'h0, s[i][31:16]});
      rc("r7", ga(7), 32'hFFFF, {16'h0, s[i][15:0]});
      rc("ov c", mbie_pkg::OFF_IND, 32'h3, f[i]);
    end
  endtask
  task automatic t_hand;
    wr(ga(2), 16'hFFFF);
    wr(mbie_pkg::OFF_OPLO, 16'h80);
    ex(mbie_pkg::OP_HALF_AND, 16'h2000, 16'h0, 16'h0);
    rc("and neg", ga(2), 32'hFFFF, 32'hFF80);
    rc("and pc", mbie_pkg::OFF_PC, 32'hFFFF, 32'h0102);
    wr(ga(2), 16'h1274);
    wr(mbie_pkg::OFF_OPLO, 16'h40);
    ex(mbie_pkg::OP_HALF_AND, 16'h2000, 16'h0, 16'h0);
    rc("and pos", ga(2), 32'hFFFF, 32'h0040);
  endtask
  task automatic t_shift;
    logic [15:0] ins [4] = '{16'hA5, 16'hA0, 16'hB5, 16'hA0};
    logic [15:0] r1 [4] = '{16'h0, 16'h7, 16'h0, 16'h13};
    logic [31:0] x [4] = '{32'h28A00, 32'h68E00, 32'h16A00, 32'h56600};
    for (int i = 0; i < 4; i++) begin
      wr(ga(1), r1[i]);
      ex(i < 2 ? mbie_pkg::OP_SHIFT_SHORT : mbie_pkg::OP_SHIFT_LONG, ins[i], 16'h0, 16'h0);
      rc("shift", mbie_pkg::OFF_STAT, 32'h7FE00, x[i]);
    end
  endtask
  task automatic t_mask;
    wr(ga(1), 16'h0F0F);
    ex(mbie_pkg::OP_MASK_DECODE, 16'h0, 16'h0, 16'h0);
    rc("mask r1", mbie_pkg::OFF_RESULT, 32'hFFFF, 32'h0F0F);
    ex(mbie_pkg::OP_MASK_DECODE, 16'h0, 16'hF0, 16'h0);
    rc("mask word", mbie_pkg::OFF_RESULT, 32'hFFFF, 32'h00F0);
    wr(ga(2), 16'hAAAA);
    wr(mbie_pkg::OFF_OPLO, 16'h5555);
    ex(mbie_pkg::OP_MASK_STORE, 16'h2000, 16'hFF00, 16'h0);
    rc("mstore", mbie_pkg::OFF_RESULT, 32'hFFFF, 32'hAA55);
    ex(mbie_pkg::OP_MASK_STORE, 16'h2000, 16'h0, 16'h0);
    rc("mstore r1", mbie_pkg::OFF_RESULT, 32'hFFFF, 32'h5A5A);
  endtask
  task automatic t_bus;
    logic [31:0] q;
    logic e;
    apb(1'b0, 8'h30, 32'h0, q, e);
    chk("unmapped", 32'h1, {31'h0, e});
    apb(1'b0, 8'h06, 32'h0, q, e);
    chk("misaligned", 32'h1, {31'h0, e});
  endtask
  task automatic summarize;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rc("pc rst", mbie_pkg::OFF_PC, 32'hFFFFFFFF, 32'h0);
    t_ind;
    t_reg;
    t_cnt;
    t_disp;
    t_brk;
    t_cmp;
    t_dadd;
    t_hand;
    t_shift;
    t_mask;
    t_bus;
    summarize;
  end
  // Watchdog, well beyond the roughly two thousand cycles the tests need
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    summarize;
  end
endmodule
`default_nettype wire
